// ### include/sfcp_byte_if.sv
/*
 * Byte carrier between the byte synchroniser and the frame parser.
 * Assumes a single clock domain.
 */
`timescale 1ns/1ps
interface sfcp_byte_if;
    logic valid;
    logic [7:0] data;
    modport src (output valid, output data);
    modport dst (input valid, input data);
endinterface

// ### include/sfcp_pkg.sv
/*
 * Package for the serial fader control parser: frame bytes, frame length
 * and field positions. Assumes bytes arrive already deserialised.
 */
package sfcp_pkg;
    localparam logic [7:0] SFCP_PREAMBLE = 8'h_F0;
    localparam logic [7:0] SFCP_LENGTH = 8'h_0E;
    localparam logic [7:0] SFCP_GROUP = 8'h_05;
    localparam logic [7:0] SFCP_SUB_FADER = 8'h_02;
    localparam logic [7:0] SFCP_FLAG_ON = 8'h_01;
    localparam logic [7:0] SFCP_FLAG_OFF = 8'h_00;
    localparam logic [7:0] SFCP_END = 8'h_FF;
    // Unit identification; value is arbitrary, override per unit
    localparam logic [7:0] SFCP_UNIT_ID_DEF = 8'h_5A;
    localparam logic [3:0] SFCP_POS_ID = 4'h_1;
    localparam logic [3:0] SFCP_POS_LEN = 4'h_2;
    localparam logic [3:0] SFCP_POS_GROUP = 4'h_3;
    localparam logic [3:0] SFCP_POS_SUB = 4'h_4;
    localparam logic [3:0] SFCP_POS_FLAG = 4'h_5;
    localparam logic [3:0] SFCP_POS_LO = 4'h_6;
    localparam logic [3:0] SFCP_POS_HI = 4'h_7;
    localparam logic [3:0] SFCP_POS_END = 4'h_D;
    localparam logic [15:0] SFCP_FADER_RST = 16'h_0000;
endpackage

// ### rtl/sfcp_byte_sync.sv
/*
 * Brings a byte strobe from the serial receiver into the clock domain.
 * Assumes the receiver holds data stable while its strobe toggles.
 */
`timescale 1ns/1ps
module sfcp_byte_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Receiver side
    input wire logic rx_toggle,
    input wire logic [7:0] rx_data,
    // Parser side
    sfcp_byte_if.src out
);
    logic [2:0] tog_q;
    logic [7:0] data_q;
    logic valid_q;
    wire logic seen = tog_q[2] ^ tog_q[1];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tog_q <= 3'h_0;
            data_q <= 8'h_00;
            valid_q <= 1'b0;
        end else begin
            tog_q <= {tog_q[1:0], rx_toggle};
            valid_q <= seen;
            // Data settled long before the toggle passes three stages
            if (seen) begin
                data_q <= rx_data;
            end
        end
    end

    assign out.valid = valid_q;
    assign out.data = data_q;
endmodule

// ### rtl/sfcp_parser.sv
/*
 * Serial fader control parser: checks fixed 14-byte frames and hands the
 * transition fader position to the serial host or back to the local lever.
 * Assumes a UART that flips rx_toggle once per received byte.
 */
`timescale 1ns/1ps
// Function
// R1: Header F0, ID, 0E, 05 else reject
// R2: Subcommand 02, flag 01 grants host control
// R3: Position low then high byte assembled
// R4: Five padding bytes ignored entirely
// R5: Flag 00 releases to local lever
// R6: Byte fourteen must be FF; resync
module sfcp_parser import sfcp_pkg::*; #(
    parameter logic [7:0] UNIT_ID = SFCP_UNIT_ID_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Serial receiver bytes
    input wire logic rx_toggle,
    input wire logic [7:0] rx_data,
    // Fader control
    input wire logic [15:0] local_fader,
    output logic remote_active,
    output logic [15:0] fader_pos,
    output logic frame_ok,
    output logic frame_err
);
    sfcp_byte_if byte_bus ();

    sfcp_byte_sync u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .rx_toggle(rx_toggle),
        .rx_data(rx_data),
        .out(byte_bus.src)
    );

    // Frame walk: hunt for a preamble, then count positions one to thirteen
    typedef enum logic {
        SFCP_HUNT,
        SFCP_BODY
    } sfcp_state_t;

    sfcp_state_t state_q;
    sfcp_state_t state_d;
    logic [3:0] idx_q;
    logic [3:0] idx_d;
    logic bad_q;
    logic bad_d;
    logic flag_q;
    logic remote_q;
    logic [15:0] remote_pos_q;
    logic [15:0] pos_q;
    logic ok_q;
    logic err_q;
    logic [15:0] lev1_q;
    logic [15:0] lev2_q;
    logic [15:0] lev3_q;
    logic [15:0] lev_q;

    // Byte strobe lands on one given frame position
    function automatic logic lands_on(input logic strobe, input logic [3:0] idx, input logic [3:0] pos);
        return strobe && (idx == pos);
    endfunction

    // Fixed-value check for one frame position; open positions pass
    function automatic logic field_wrong(input logic [3:0] pos, input logic [7:0] val);
        logic wrong;
        wrong = 1'b0;
        unique case (pos)
            SFCP_POS_ID: begin
                wrong = (val != UNIT_ID); // R1
            end
            SFCP_POS_LEN: begin
                wrong = (val != SFCP_LENGTH); // R1
            end
            SFCP_POS_GROUP: begin
                wrong = (val != SFCP_GROUP); // R1
            end
            SFCP_POS_SUB: begin
                wrong = (val != SFCP_SUB_FADER); // R2
            end
            SFCP_POS_FLAG: begin
                wrong = (val != SFCP_FLAG_ON) && (val != SFCP_FLAG_OFF); // R2 R5
            end
            SFCP_POS_END: begin
                wrong = (val != SFCP_END); // R6
            end
            // Position and padding bytes take any value
            default: begin
                wrong = 1'b0; // R4
            end
        endcase
        return wrong;
    endfunction

    wire logic [7:0] b = byte_bus.data;
    wire logic v = byte_bus.valid;
    wire logic hunting = (state_q == SFCP_HUNT);
    wire logic take = v && !hunting;
    wire logic is_pre = (b == SFCP_PREAMBLE);
    wire logic field_bad = field_wrong(idx_q, b); // R1 R2 R6
    wire logic last = lands_on(1'b1, idx_q, SFCP_POS_END);
    // A whole frame counts only if every fixed byte matched, FF included
    wire logic accept = take && last && !bad_q && !field_bad; // R6
    wire logic err_now = take && (field_bad || (last && bad_q)); // R1 R6
    wire logic flag_hit = lands_on(take, idx_q, SFCP_POS_FLAG);

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        bad_d = bad_q;
        if (v) begin
            unique case (state_q)
                SFCP_HUNT: begin
                    idx_d = SFCP_POS_ID;
                    bad_d = 1'b0;
                    if (is_pre) begin
                        state_d = SFCP_BODY; // R1
                    end
                end
                SFCP_BODY: begin
                    idx_d = last ? 4'h_0 : idx_q + 4'h_1;
                    bad_d = bad_q || field_bad; // R1
                    // A preamble inside a rejected byte is not reused
                    if (last || field_bad) begin
                        state_d = SFCP_HUNT; // R6
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SFCP_HUNT;
            idx_q <= 4'h_0;
            bad_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            bad_q <= bad_d;
        end
    end

    // Flag kept apart from the live state until the frame ends clean
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (flag_hit) begin
            flag_q <= (b == SFCP_FLAG_ON); // R2 R5
        end
    end

    // Low byte fills slot zero, high byte slot one
    for (genvar g = 0; g < 2; g++) begin : g_pos_byte
        logic [7:0] byte_q;
        wire logic hit = lands_on(take, idx_q, 4'(SFCP_POS_LO + g));
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                byte_q <= 8'h_00;
            end else if (hit) begin
                byte_q <= b; // R3
            end
        end
    end
    wire logic [15:0] host_pos = {g_pos_byte[1].byte_q, g_pos_byte[0].byte_q}; // R3

    // State changes only on a whole, checked frame
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            remote_q <= 1'b0;
            remote_pos_q <= SFCP_FADER_RST;
        end else if (accept) begin
            remote_q <= flag_q; // R2 R5
            remote_pos_q <= flag_q ? host_pos : SFCP_FADER_RST; // R3 R5
        end
    end

    // Lever word comes from another domain: taken only when stages two and
    // three agree, so a word caught mid-change is never used; costs lag
    wire logic lev_agree = (lev2_q == lev3_q);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lev1_q <= SFCP_FADER_RST;
            lev2_q <= SFCP_FADER_RST;
            lev3_q <= SFCP_FADER_RST;
            lev_q <= SFCP_FADER_RST;
        end else begin
            lev1_q <= local_fader;
            lev2_q <= lev1_q;
            lev3_q <= lev2_q;
            if (lev_agree) begin
                lev_q <= lev3_q;
            end
        end
    end

    // Position in use follows the owner one cycle after it flips
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pos_q <= SFCP_FADER_RST;
        end else begin
            pos_q <= remote_q ? remote_pos_q : lev_q; // R5
        end
    end

    // Result pulses stand one cycle each
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ok_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ok_q <= accept; // R2
            err_q <= err_now; // R1 R6
        end
    end

    assign remote_active = remote_q;
    assign fader_pos = pos_q;
    assign frame_ok = ok_q;
    assign frame_err = err_q;
endmodule

// ### tb/sfcp_host_model.sv
/* Host model: frames sent as toggled bytes.
   Assumes the bench seeds $urandom. */
`timescale 1ns/1ps
module sfcp_host_model import sfcp_pkg::*; (
    // Byte link
    input wire logic clock,
    output logic rx_toggle = 1'b0,
    output logic [7:0] rx_data = 8'h_00
);
    // Data leads the strobe; idle cycles cover the sync delay
    task automatic send_byte(input logic [7:0] b);
        @(posedge clock) #1;
        rx_data = b;
        @(posedge clock) #1;
        rx_toggle = ~rx_toggle;
        repeat (5) @(posedge clock);
    endtask
    // Fill kept below F0 so a broken frame cannot restart early
    task automatic send_frame(input logic [7:0] h [6], input logic [15:0] p);
        send_byte(8'($urandom) & 8'h_7F);
        send_byte(SFCP_PREAMBLE);
        for (int i = 0; i < 5; i++) send_byte(h[i]);
        send_byte(p[7:0]);
        send_byte(p[15:8]);
        repeat (5) send_byte(8'($urandom) & 8'h_7F);
        send_byte(h[5]);
    endtask
endmodule

// ### tb/sfcp_parser_assertions.sv
/* Port checker for the fader parser.
   Assumes a bind onto sfcp_parser. */
`timescale 1ns/1ps
module sfcp_parser_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Watched ports
    input wire logic [15:0] local_fader,
    input wire logic remote_active,
    input wire logic [15:0] fader_pos,
    input wire logic frame_ok,
    input wire logic frame_err
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    chk_pulse_apart: assert property (!(frame_ok && frame_err)) else $error("overlap");
    chk_ok_single: assert property (frame_ok |=> !frame_ok) else $error("long ok");
    chk_owner_on_ok: assert property ($changed(remote_active) |-> frame_ok) else $error("owner moved");
    chk_err_keeps: assert property (frame_err |=> $stable(remote_active)) else $error("err moved");
    // Lever passes a three-stage synchroniser, so it needs several calm cycles
    chk_local_used: assert property ((!remote_active && $stable(local_fader)) [*6]
        |-> fader_pos == local_fader) else $error("local lost");
    chk_remote_held: assert property (remote_active && $past(remote_active) && !$past(frame_ok, 1)
        && !$past(frame_ok, 2) |-> $stable(fader_pos)) else $error("pos moved");
endmodule

// ### tb/tb_serial_fader_control_parser.sv
/* Bench for the fader parser.
   Assumes the host model and checker. */
`timescale 1ns/1ps
module tb_serial_fader_control_parser import sfcp_pkg::*;;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic rx_toggle, remote_active, frame_ok, frame_err;
    logic [7:0] rx_data;
    logic [15:0] local_fader = 16'h_0000;
    logic [15:0] fader_pos, pos;
    logic [7:0] h [6];
    int n_errors = 0;
    int num_checks = 0;
    int n_ok, n_bad;
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        n_ok += frame_ok;
        n_bad += frame_err;
    end
    sfcp_host_model HOST (.clock(clock), .rx_toggle(rx_toggle), .rx_data(rx_data));
    sfcp_parser DUT (.clock(clock), .rst_b(rst_b), .rx_toggle(rx_toggle), .rx_data(rx_data),
        .local_fader(local_fader), .remote_active(remote_active), .fader_pos(fader_pos),
        .frame_ok(frame_ok), .frame_err(frame_err));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Expected position: host value while it holds control, else the lever
    function automatic logic [15:0] exp_pos(input logic host, input logic [15:0] hp, input logic [15:0] lever);
        return host ? hp : lever;
    endfunction
    // Any nonzero error count passes for a bad frame; a good frame needs zero
    task automatic frame(input bit good, input logic [7:0] flg, input int bad, input logic [15:0] p);
        h = '{SFCP_UNIT_ID_DEF, SFCP_LENGTH, SFCP_GROUP, SFCP_SUB_FADER, flg, SFCP_END};
        if (bad >= 0) h[bad] ^= 8'h_81;
        n_ok = 0;
        n_bad = 0;
        HOST.send_frame(h, p);
        repeat (3) @(posedge clock);
        #1;
        chk("frame_ok", 16'(good), 16'(n_ok));
        chk("frame_err", 16'(!good), 16'(n_bad != 0));
    endtask
    initial begin
        void'($urandom(32'h_af62));
        repeat (2) @(posedge clock);
        #1;
        rst_b = 1'b1;
        for (int k = 0; k < 10; k++) begin
            if (k < 4) pos = 16'($urandom);
            local_fader = 16'($urandom);
            frame(k < 4, SFCP_FLAG_ON, k - 4, k < 4 ? pos : 16'h_0102);
            chk("fader_pos", exp_pos(1'b1, pos, local_fader), fader_pos);
            chk("remote_active", 16'h_0001, 16'(remote_active));
        end
        // Mid-run reset drops host control at once
        rst_b = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("remote_active", 16'h_0000, 16'(remote_active));
        chk("fader_pos", SFCP_FADER_RST, fader_pos);
        rst_b = 1'b1;
        frame(1'b1, SFCP_FLAG_ON, -1, 16'h_FFFF);
        chk("fader_pos", exp_pos(1'b1, 16'h_FFFF, local_fader), fader_pos);
        frame(1'b1, SFCP_FLAG_OFF, -1, 16'h_0000);
        chk("fader_pos", exp_pos(1'b0, 16'h_0000, local_fader), fader_pos);
        chk("remote_active", 16'h_0000, 16'(remote_active));
        summarize();
    end
    initial begin
        #200us;
        n_errors++;
        summarize();
    end
endmodule
bind sfcp_parser sfcp_parser_assertions CHK (.clock(clock), .rst_b(rst_b), .local_fader(local_fader),
    .remote_active(remote_active), .fader_pos(fader_pos), .frame_ok(frame_ok), .frame_err(frame_err));
